// [verilog/wd_defines.vh]
// constants for the program-loop watchdog
// Functional notes
// - counter advances only on low-speed oscillator edges, not on cpu clock
// - count reaching selected overflow without a key write forces an internal reset
// - any single-bit manipulation access to the service register forces reset
// - writing any byte other than 0xAC to the service register forces reset
// - byte write of 0xAC clears the counter and restarts from zero
// - a watchdog reset sets the reset-cause flag, bit 4 of cause register
// - interval interrupt fires when count reaches three quarters of period
// - period select picks 2^n, n in 6,7,8,9,11,13,14,16; overflow 2^n-1
// - enable bit 0 keeps counter stopped, 1 starts it at reset release
// - standby bit 0 freezes counter in halt/stop, 1 keeps it counting
// - standby bit 0: counter cleared and restarted on standby release
// - service register resets to 0x1A if disabled, 0x9A if enabled
// - service register reads give its reset value, never the written key
// - restart by key may shorten next period by up to one oscillator cycle
// - interval interrupt does not stop or clear the counter
// - interval request always raised; software masks it outside if unwanted
// - key write in the cycle just before overflow still restarts counter
`ifndef WD_DEFINES_VH
`define WD_DEFINES_VH

`define WD_ADDR_W        20
`define WD_SVC_ADDR      20'hFFFAB
`define WD_CFG_ADDR      20'h000C0
`define WD_KEY_VALUE     8'hAC
`define WD_SVC_RST_OFF   8'h1A
`define WD_SVC_RST_ON    8'h9A
`define WD_CFG_EN_BIT    4
`define WD_CFG_SEL_MSB   3
`define WD_CFG_SEL_LSB   1
`define WD_CFG_STBY_BIT  0
`define WD_CAUSE_BIT     4
`define WD_CNT_W         16
`define WD_SEL_W         3
`define WD_EXP_W         5
`define WD_EXP_SEL0      5'h06
`define WD_EXP_SEL1      5'h07
`define WD_EXP_SEL2      5'h08
`define WD_EXP_SEL3      5'h09
`define WD_EXP_SEL4      5'h0B
`define WD_EXP_SEL5      5'h0D
`define WD_EXP_SEL6      5'h0E
`define WD_EXP_SEL7      5'h10
`define WD_TRIP_NONE     2'h0
`define WD_TRIP_OVF      2'h1
`define WD_TRIP_KEY      2'h2
`define WD_TRIP_BITOP    2'h3

`endif

// [verilog/wd_period_decode.v]
// decodes the period select into overflow and interval counts
`include "wd_defines.vh"
`default_nettype none

module wd_period_decode #(
    parameter CNT_W = `WD_CNT_W
) (
    input  wire [`WD_SEL_W-1:0] sel_i,
    output wire [CNT_W-1:0]     ovf_count_o,
    output wire [CNT_W-1:0]     irq_count_o
);

    function [`WD_EXP_W-1:0] exp_of;
        input [`WD_SEL_W-1:0] sel;
        begin
            case (sel)
                3'h0:    exp_of = `WD_EXP_SEL0;
                3'h1:    exp_of = `WD_EXP_SEL1;
                3'h2:    exp_of = `WD_EXP_SEL2;
                3'h3:    exp_of = `WD_EXP_SEL3;
                3'h4:    exp_of = `WD_EXP_SEL4;
                3'h5:    exp_of = `WD_EXP_SEL5;
                3'h6:    exp_of = `WD_EXP_SEL6;
                default: exp_of = `WD_EXP_SEL7;
            endcase
        end
    endfunction

    wire [`WD_EXP_W-1:0] n;
    wire [31:0]          full;
    wire [31:0]          ovf_wide;
    wire [31:0]          irq_wide;

    assign n        = exp_of(sel_i);
    assign full     = 32'h00000001 << n;
    assign ovf_wide = full - 32'h00000001;
    // three quarters of 2^n is 3 * 2^(n-2); n is never below 6
    assign irq_wide = (full >> 2) * 32'h00000003;
    assign ovf_count_o = ovf_wide[CNT_W-1:0];
    assign irq_count_o = irq_wide[CNT_W-1:0];

endmodule

`default_nettype wire

// [verilog/program_loop_watchdog.v]
// program-loop watchdog: service register, counter and reset request
`include "wd_defines.vh"
`default_nettype none

module program_loop_watchdog #(
    parameter CNT_W  = `WD_CNT_W,
    parameter ADDR_W = `WD_ADDR_W
) (
    input  wire              clock_i,
    input  wire              resetn_i,
    input  wire              low_speed_osc_i,
    input  wire [7:0]        opt_byte_i,
    input  wire [ADDR_W-1:0] cpu_addr_i,
    input  wire              cpu_wr_i,
    input  wire              cpu_rd_i,
    input  wire              cpu_bitop_i,
    input  wire [7:0]        cpu_wdata_i,
    input  wire              halt_i,
    input  wire              stop_i,
    input  wire              cause_clear_i,
    output reg  [7:0]        cpu_rdata_o,
    output reg               cpu_rvalid_o,
    output reg               wd_interval_irq_o,
    output reg               wd_reset_o,
    output reg               wd_reset_cause_flag_o,
    output reg  [1:0]        wd_trip_cause_o,
    output reg  [CNT_W-1:0]  wd_count_o,
    output reg               wd_running_o
);

    ////////////////////////////////////////////////////////////////////////
    // state codes

    localparam [2:0] ST_LOAD    = 3'h0;
    localparam [2:0] ST_STOPPED = 3'h1;
    localparam [2:0] ST_RUN     = 3'h2;
    localparam [2:0] ST_HOLD    = 3'h3;
    localparam [2:0] ST_TRIP    = 3'h4;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    reg  [2:0]           state;
    reg  [2:0]           next_state;
    reg  [CNT_W-1:0]     count;
    reg  [CNT_W-1:0]     next_count;
    reg                  next_irq;
    reg  [1:0]           next_cause;
    reg  [CNT_W-1:0]     count_inc;

    reg                  cfg_en;
    reg  [`WD_SEL_W-1:0] cfg_sel;
    reg                  cfg_stby_run;
    reg  [7:0]           cfg_byte;

    reg                  osc_prev;

    wire                 osc_rise;
    wire                 standby;
    wire                 svc_sel;
    wire                 cfg_sel_hit;
    wire                 key_ok;
    wire                 key_bad;
    wire                 bit_access;
    wire                 bad_access;
    wire [CNT_W-1:0]     ovf_count;
    wire [CNT_W-1:0]     irq_count;
    wire [7:0]           svc_read_value;
    wire                 trip_now;

    ////////////////////////////////////////////////////////////////////////
    // period decode

    wd_period_decode #(
        .CNT_W       (CNT_W)
    ) u_period (
        .sel_i       (cfg_sel),
        .ovf_count_o (ovf_count),
        .irq_count_o (irq_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // oscillator edge detect; the oscillator is slow against clock_i and
    // arrives already synchronous, so one stage suffices

    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            osc_prev <= 1'b0;
        end else begin
            osc_prev <= low_speed_osc_i;
        end
    end

    assign osc_rise = low_speed_osc_i & ~osc_prev;
    assign standby  = halt_i | stop_i;

    ////////////////////////////////////////////////////////////////////////
    // access decode

    assign svc_sel     = (cpu_addr_i == `WD_SVC_ADDR);
    assign cfg_sel_hit = (cpu_addr_i == `WD_CFG_ADDR);

    // a bit manipulation is a read-modify-write; either half trips
    assign bit_access = svc_sel & cpu_bitop_i & (cpu_wr_i | cpu_rd_i);

    assign key_ok  = svc_sel & cpu_wr_i & ~cpu_bitop_i
                   & (cpu_wdata_i == `WD_KEY_VALUE);
    assign key_bad = svc_sel & cpu_wr_i & ~cpu_bitop_i
                   & (cpu_wdata_i != `WD_KEY_VALUE);

    assign bad_access = bit_access | key_bad;

    assign svc_read_value = cfg_en ? `WD_SVC_RST_ON
                                   : `WD_SVC_RST_OFF;

    ////////////////////////////////////////////////////////////////////////
    // configuration capture, once after reset release

    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_en       <= 1'b0;
            cfg_sel      <= {`WD_SEL_W{1'b0}};
            cfg_stby_run <= 1'b0;
            cfg_byte     <= 8'h00;
        end else if (state == ST_LOAD) begin
            // option byte sampled by the clock, never by the reset itself
            cfg_en       <= opt_byte_i[`WD_CFG_EN_BIT];
            cfg_sel      <= opt_byte_i[`WD_CFG_SEL_MSB:`WD_CFG_SEL_LSB];
            cfg_stby_run <= opt_byte_i[`WD_CFG_STBY_BIT];
            cfg_byte     <= opt_byte_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter and state machine, next values

    always @* begin
        next_state = state;
        next_count = count;
        next_irq   = 1'b0;
        next_cause = `WD_TRIP_NONE;
        count_inc  = count + {{(CNT_W-1){1'b0}}, 1'b1};
        case (state)
            ST_LOAD: begin
                next_count = {CNT_W{1'b0}};
                if (opt_byte_i[`WD_CFG_EN_BIT]) begin
                    next_state = ST_RUN;
                end else begin
                    next_state = ST_STOPPED;
                end
            end
            ST_STOPPED: begin
                next_count = {CNT_W{1'b0}};
            end
            ST_RUN: begin
                if (key_ok) begin
                    // clear beats a same-cycle oscillator edge, so the
                    // first period after a restart may lose one edge
                    next_count = {CNT_W{1'b0}};
                end else if (standby && !cfg_stby_run) begin
                    next_state = ST_HOLD;
                end else if (osc_rise) begin
                    next_count = count_inc;
                    if (count_inc == irq_count) begin
                        next_irq = 1'b1;
                    end
                    if (count_inc == ovf_count) begin
                        next_state = ST_TRIP;
                        next_cause = `WD_TRIP_OVF;
                    end
                end
            end
            ST_HOLD: begin
                if (!standby) begin
                    next_state = ST_RUN;
                    next_count = {CNT_W{1'b0}};
                end
            end
            ST_TRIP: begin
                next_count = count;
            end
            default: begin
                next_state = ST_LOAD;
                next_count = {CNT_W{1'b0}};
            end
        endcase
        // software faults trip from any live state, counting or not
        if (bad_access && state != ST_LOAD && state != ST_TRIP) begin
            next_state = ST_TRIP;
            next_irq   = 1'b0;
            if (bit_access) begin
                next_cause = `WD_TRIP_BITOP;
            end else begin
                next_cause = `WD_TRIP_KEY;
            end
        end
    end

    assign trip_now = (next_state == ST_TRIP) && (state != ST_TRIP);

    ////////////////////////////////////////////////////////////////////////
    // counter and state registers

    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ST_LOAD;
            count <= {CNT_W{1'b0}};
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset request and cause reporting

    // the request holds until the system reset comes back around
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wd_reset_o      <= 1'b0;
            wd_trip_cause_o <= `WD_TRIP_NONE;
        end else if (trip_now) begin
            wd_reset_o      <= 1'b1;
            wd_trip_cause_o <= next_cause;
        end
    end

    // cause flag: a new trip wins over a clear in the same cycle
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wd_reset_cause_flag_o <= 1'b0;
        end else if (trip_now) begin
            wd_reset_cause_flag_o <= 1'b1;
        end else if (cause_clear_i) begin
            wd_reset_cause_flag_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interval interrupt and status outputs

    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wd_interval_irq_o <= 1'b0;
            wd_count_o        <= {CNT_W{1'b0}};
            wd_running_o      <= 1'b0;
        end else begin
            wd_interval_irq_o <= next_irq;
            wd_count_o        <= next_count;
            wd_running_o      <= (next_state == ST_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: one cycle after the strobe

    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cpu_rdata_o  <= 8'h00;
            cpu_rvalid_o <= 1'b0;
        end else begin
            cpu_rvalid_o <= cpu_rd_i;
            if (cpu_rd_i && svc_sel) begin
                cpu_rdata_o <= svc_read_value;
            end else if (cpu_rd_i && cfg_sel_hit) begin
                cpu_rdata_o <= cfg_byte;
            end else if (cpu_rd_i) begin
                cpu_rdata_o <= 8'h00;
            end
        end
    end

endmodule

`default_nettype wire

// [tb/wd_monitor.sv]
// assertion checker bound to the program-loop watchdog ports
`include "wd_defines.vh"
`default_nettype none
module wd_monitor #(
    parameter CNT_W  = 16,
    parameter ADDR_W = 20
) (
    input wire logic              clock_i,
    input wire logic              resetn_i,
    input wire logic [7:0]        opt_byte_i,
    input wire logic [ADDR_W-1:0] cpu_addr_i,
    input wire logic              cpu_wr_i,
    input wire logic              cpu_rd_i,
    input wire logic              cpu_bitop_i,
    input wire logic [7:0]        cpu_wdata_i,
    input wire logic              halt_i,
    input wire logic              stop_i,
    input wire logic [7:0]        cpu_rdata_o,
    input wire logic              cpu_rvalid_o,
    input wire logic              wd_interval_irq_o,
    input wire logic              wd_reset_o,
    input wire logic              wd_reset_cause_flag_o,
    input wire logic [1:0]        wd_trip_cause_o,
    input wire logic [CNT_W-1:0]  wd_count_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int E [8] = '{6, 7, 8, 9, 11, 13, 14, 16};
    wire [31:0] n      = E[opt_byte_i[3:1]];
    wire [31:0] irq_pt = 32'h3 << (n - 32'h2);
    wire [31:0] ovf_pt = (32'h1 << n) - 32'h1;
    wire        svc    = cpu_addr_i == `WD_SVC_ADDR;
    wire        stby   = halt_i | stop_i;
    wire        live   = !wd_reset_o && svc;
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////////////////////////////////////
    property p_key_clear;
        cpu_wr_i && live && !cpu_bitop_i && cpu_wdata_i == `WD_KEY_VALUE
            |=> wd_count_o == '0;
    endproperty
    a_key_clear: assert property (p_key_clear)
        else $error("count not cleared by key write");
    property p_bad_key;
        cpu_wr_i && live && !cpu_bitop_i && cpu_wdata_i != `WD_KEY_VALUE
            |=> wd_reset_o && wd_trip_cause_o == `WD_TRIP_KEY;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("wrong key did not trip");
    property p_bitop;
        (cpu_wr_i || cpu_rd_i) && live && cpu_bitop_i
            |=> wd_reset_o && wd_trip_cause_o == `WD_TRIP_BITOP;
    endproperty
    a_bitop: assert property (p_bitop)
        else $error("bit access did not trip");
    property p_flag;
        $rose(wd_reset_o) |-> wd_reset_cause_flag_o;
    endproperty
    a_flag: assert property (p_flag)
        else $error("cause flag missing on trip");
    property p_ovf;
        wd_count_o == ovf_pt[CNT_W-1:0]
            |-> wd_reset_o && wd_trip_cause_o == `WD_TRIP_OVF;
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("no trip at overflow count");
    property p_irq;
        wd_interval_irq_o |-> wd_count_o == irq_pt[CNT_W-1:0]
            ##1 !wd_interval_irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interval pulse at wrong count");
    property p_read;
        cpu_rd_i && svc && !cpu_bitop_i |=> cpu_rvalid_o && cpu_rdata_o ==
            (opt_byte_i[4] ? `WD_SVC_RST_ON : `WD_SVC_RST_OFF);
    endproperty
    a_read: assert property (p_read)
        else $error("service read value wrong");
    property p_stopped;
        !opt_byte_i[4] |-> wd_count_o == '0;
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("disabled counter moved");
    property p_hold;
        stby && !opt_byte_i[0] && !cpu_wr_i |=> $stable(wd_count_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved in standby");
    property p_wake;
        $past(stby) && !stby && !opt_byte_i[0] |=> wd_count_o <= 1;
    endproperty
    a_wake: assert property (p_wake)
        else $error("counter not cleared on wake");
    c_irq: cover property (wd_interval_irq_o);
    c_ovf: cover property (wd_trip_cause_o == `WD_TRIP_OVF);
    c_bitop: cover property (wd_trip_cause_o == `WD_TRIP_BITOP);
endmodule
bind program_loop_watchdog wd_monitor #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) mon (
    .clock_i(clock_i), .resetn_i(resetn_i), .opt_byte_i(opt_byte_i),
    .cpu_addr_i(cpu_addr_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
    .cpu_bitop_i(cpu_bitop_i), .cpu_wdata_i(cpu_wdata_i),
    .halt_i(halt_i), .stop_i(stop_i), .cpu_rdata_o(cpu_rdata_o),
    .cpu_rvalid_o(cpu_rvalid_o), .wd_interval_irq_o(wd_interval_irq_o),
    .wd_reset_o(wd_reset_o), .wd_reset_cause_flag_o(wd_reset_cause_flag_o),
    .wd_trip_cause_o(wd_trip_cause_o), .wd_count_o(wd_count_o));
`default_nettype wire

// [tb/program_loop_watchdog_tb_top.sv]
// self-checking bench for the program-loop watchdog
`include "wd_defines.vh"
`default_nettype none
module program_loop_watchdog_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_i = 0, resetn_i = 0, osc = 0, wr = 0, rd = 0;
    logic        bop = 0, halt = 0, stop = 0, cclr = 0;
    logic [7:0]  opt = 0, wdata = 0;
    logic [19:0] addr = 0;
    wire  [7:0]  rdat;
    wire  [15:0] cnt;
    wire  [1:0]  cause;
    wire         rv, irq, wrst, flag, run;
    int          mismatches = 0, n_checks = 0, seed = 32'h22EC;
    int          m_cnt, n_irq, irq_at, k, ovf;
    int          e [8] = '{6, 7, 8, 9, 11, 13, 14, 16};
    program_loop_watchdog uut (
        .clock_i(clock_i), .resetn_i(resetn_i), .low_speed_osc_i(osc),
        .opt_byte_i(opt), .cpu_addr_i(addr), .cpu_wr_i(wr), .cpu_rd_i(rd),
        .cpu_bitop_i(bop), .cpu_wdata_i(wdata), .halt_i(halt),
        .stop_i(stop), .cause_clear_i(cclr), .cpu_rdata_o(rdat),
        .cpu_rvalid_o(rv), .wd_interval_irq_o(irq), .wd_reset_o(wrst),
        .wd_reset_cause_flag_o(flag), .wd_trip_cause_o(cause),
        .wd_count_o(cnt), .wd_running_o(run));
    always #50 clock_i = ~clock_i;
    // negedge sampling keeps the pulse count clear of edge races
    always @(negedge clock_i) if (irq === 1'b1) begin
        n_irq++;
        irq_at = m_cnt;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // configuration is only sampled after release, so it moves under reset
    task boot(input logic [7:0] o);
        @(posedge clock_i) resetn_i <= 0;
        opt <= o;
        repeat (6) @(posedge clock_i);
        resetn_i <= 1;
        repeat (2) @(posedge clock_i);
        m_cnt = 0;
        n_irq = 0;
    endtask
    task acc(input logic w, b, input logic [19:0] a, input logic [7:0] d);
        @(posedge clock_i) wr <= w;
        rd <= !w;
        bop <= b;
        addr <= a;
        wdata <= d;
        @(posedge clock_i) wr <= 0;
        rd <= 0;
        bop <= 0;
        #1;
    endtask
    task tick(input int t);
        repeat (t) begin
            @(posedge clock_i) osc <= 1;
            @(posedge clock_i) osc <= 0;
            #1 if (opt[4] && !((halt | stop) && !opt[0])) m_cnt++;
            chk("count", cnt, m_cnt[15:0]);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        for (int s = 0; s < 8; s++) begin
            ovf = (1 << e[s]) - 1;
            boot({3'h0, 1'b1, s[2:0], 1'b0});
            acc(0, 0, `WD_SVC_ADDR, 8'h00);
            chk("svc read", {rv, rdat}, {1'b1, `WD_SVC_RST_ON});
            chk("running", run, 1'b1);
            acc(0, 0, `WD_CFG_ADDR, 8'h00);
            chk("cfg read", rdat, opt);
            k = (s == 0) ? ovf - 1 : {$random(seed)} % 64;
            tick(k);
            acc(1, 0, `WD_SVC_ADDR, `WD_KEY_VALUE);
            m_cnt = 0;
            n_irq = 0;
            chk("cleared", cnt, 16'h0000);
            if (s < 7) begin
                tick(ovf);
                chk("irq n", n_irq[15:0], 16'h0001);
                chk("irq at", irq_at[15:0], 16'(3 << (e[s] - 2)));
                chk("ovf", {wrst, flag, cause}, {3'h3, 2'h1});
            end else begin
                tick(1000);
                chk("no trip", wrst, 1'b0);
            end
        end
        boot(8'h10);
        k = $random(seed);
        acc(1, 0, `WD_SVC_ADDR, (k[7:0] == 8'hAC) ? 8'h55 : k[7:0]);
        chk("bad key", {wrst, flag, cause}, {3'h3, 2'h2});
        chk("halted", run, 1'b0);
        @(posedge clock_i) cclr <= 1;
        @(posedge clock_i) cclr <= 0;
        #1 chk("flag clear", flag, 1'b0);
        for (int w = 0; w < 2; w++) begin
            boot(8'h10);
            acc(0, 0, 20'h00001, 8'h00);
            chk("unmapped", rdat, 8'h00);
            acc(w[0], 1, `WD_SVC_ADDR, `WD_KEY_VALUE);
            chk("bit access", {wrst, cause}, {1'b1, 2'h3});
        end
        boot(8'h02);
        acc(0, 0, `WD_SVC_ADDR, 8'h00);
        chk("off read", rdat, `WD_SVC_RST_OFF);
        chk("stopped", run, 1'b0);
        tick(20);
        for (int b = 0; b < 2; b++) begin
            boot({4'h1, 3'h2, b[0]});
            tick(5);
            @(posedge clock_i) halt <= !b[0];
            stop <= b[0];
            tick(5);
            @(posedge clock_i) halt <= 0;
            stop <= 0;
            @(posedge clock_i) #1 if (!opt[0]) m_cnt = 0;
            chk("wake", cnt, m_cnt[15:0]);
        end
        conclude;
    end
    initial begin
        // the longest scenario set needs about 60000 cycles
        #(90000 * 100);
        mismatches++;
        conclude;
    end
endmodule
`default_nettype wire
